// [logic/sdas_pkg.sv]
// Package for the delta-sigma conversion sequencer.
// Assumes one system clock; holds modes, counts, limits and carriers.
package sdas_pkg;
  // Conversion modes selected by the controlling party.
  typedef enum logic [1:0] {
    SDAS_MODE_SINGLE = 2'h0,
    SDAS_MODE_MULTI = 2'h1,
    SDAS_MODE_CONT = 2'h2,
    SDAS_MODE_TURBO = 2'h3
  } sdas_mode_e;
  // Samples held in the decimator pipeline.
  localparam int SDAS_PIPE_DEPTH = 4;
  // Conversions that only prime the pipeline.
  localparam int SDAS_PRIME_CONV = 3;
  // Least and most resolution for the turbo shortcut.
  localparam logic [4:0] SDAS_TURBO_MIN_RES = 5'h11;
  localparam logic [4:0] SDAS_TURBO_MAX_RES = 5'h14;
  // Default modulator bits accumulated per conversion.
  localparam int SDAS_OSR_DEFAULT = 16;
  // Reset value of the done status.
  localparam logic SDAS_DONE_RST = 1'b0;
  // Configuration carried as one group.
  typedef struct packed {
    sdas_mode_e mode;
    logic [4:0] resolution;
  } sdas_cfg_s;
endpackage : sdas_pkg

// [logic/sdas_sequencer.sv]
// Conversion sequencer and decimator for an oversampling converter.
// Assumes the modulator bit, start strobe and mux-change arrive from
// outside the clock domain; read strobe and config come from local logic.
`timescale 1ns/1ps
`default_nettype none
module sdas_sequencer
  import sdas_pkg::*;
#(
  parameter int OSR = SDAS_OSR_DEFAULT,
  parameter int RES_W = 20
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic clk_en_in,
  input wire sdas_cfg_s cfg_in,
  input wire logic start_bit_in,
  input wire logic start_strobe_in,
  input wire logic stop_in,
  input wire logic mod_bit_in,
  input wire logic mux_change_in,
  input wire logic result_read_in,
  output logic [RES_W-1:0] result_out,
  output logic done_out,
  output logic status_out,
  output logic busy_out
);
  //////////////////////////////////////////////////////////////////////
  localparam int CW = $clog2(OSR + 1);
  localparam int SW = CW + 2;
  // Sequencer states, one-hot.
  typedef enum logic [3:0] {
    SDAS_ST_STANDBY = 4'b0001,
    SDAS_ST_PRIME = 4'b0010,
    SDAS_ST_RUN = 4'b0100,
    SDAS_ST_WAIT = 4'b1000
  } sdas_state_e;
  sdas_state_e state_q;
  // Three-stage synchronisers; stage one feeds only stage two.
  logic [2:0] bit_sync_q;
  logic [2:0] soc_sync_q;
  logic [2:0] mux_sync_q;
  logic bit_val_q; // Filtered modulator bit.
  logic soc_lvl_q; // Filtered start strobe level.
  logic mux_lvl_q; // Filtered mux-change level.
  logic soc_pulse; // Rising edge of the filtered strobe.
  logic mux_pulse; // Rising edge of the filtered mux change.
  logic start_ev; // Any start request.
  logic [CW-1:0] osr_cnt_q; // Bits taken in the current conversion.
  logic [CW-1:0] acc_q; // Ones counted in the current conversion.
  logic [CW-1:0] pipe_q [SDAS_PIPE_DEPTH]; // Last four conversions.
  logic [2:0] fill_q; // Valid conversions in the pipeline.
  logic conv_end; // Last modulator bit of a conversion.
  logic [SW-1:0] pipe_sum; // Sum of the new entry and the three newest pipeline entries.
  logic turbo_long; // Turbo with 17 to 20 bits resolution.
  logic restart_each; // Clear pipeline before every sample.
  logic result_ready; // A valid result is produced this cycle.
  //////////////////////////////////////////////////////////////////////
  // Synchronise the outside pins; a change counts when stages 2 and 3
  // agree, which rejects a single-cycle glitch at the cost of latency.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bit_sync_q <= 3'h0;
      soc_sync_q <= 3'h0;
      mux_sync_q <= 3'h0;
      bit_val_q <= 1'b0;
      soc_lvl_q <= 1'b0;
      mux_lvl_q <= 1'b0;
    end else if (clk_en_in) begin
      bit_sync_q <= {bit_sync_q[1:0], mod_bit_in};
      soc_sync_q <= {soc_sync_q[1:0], start_strobe_in};
      mux_sync_q <= {mux_sync_q[1:0], mux_change_in};
      if (bit_sync_q[1] == bit_sync_q[2]) begin
        bit_val_q <= bit_sync_q[2];
      end
      if (soc_sync_q[1] == soc_sync_q[2]) begin
        soc_lvl_q <= soc_sync_q[2];
      end
      if (mux_sync_q[1] == mux_sync_q[2]) begin
        mux_lvl_q <= mux_sync_q[2];
      end
    end
  end
  // Edges are taken between stage three and the filtered level, so an
  // unconnected (low) strobe simply never starts anything.
  assign soc_pulse = soc_sync_q[2] && (soc_sync_q[1] == soc_sync_q[2])
    && !soc_lvl_q;
  assign mux_pulse = mux_sync_q[2] && (mux_sync_q[1] == mux_sync_q[2])
    && !mux_lvl_q;
  assign start_ev = start_bit_in || soc_pulse;
  //////////////////////////////////////////////////////////////////////
  // Turbo shortcut applies only between 17 and 20 bits.
  assign turbo_long = (cfg_in.mode == SDAS_MODE_TURBO) &&
    (cfg_in.resolution >= SDAS_TURBO_MIN_RES) &&
    (cfg_in.resolution <= SDAS_TURBO_MAX_RES);
  assign restart_each = (cfg_in.mode == SDAS_MODE_MULTI) ||
    ((cfg_in.mode == SDAS_MODE_TURBO) && !turbo_long);
  //////////////////////////////////////////////////////////////////////
  // Oversampling counter and ones accumulator; a conversion spans OSR
  // modulator bits while the sequencer is converting.
  assign conv_end = (osr_cnt_q == CW'(OSR - 1)) &&
    ((state_q == SDAS_ST_PRIME) || (state_q == SDAS_ST_RUN));
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      osr_cnt_q <= '0;
      acc_q <= '0;
    end else if (clk_en_in) begin
      if ((state_q == SDAS_ST_PRIME) || (state_q == SDAS_ST_RUN)) begin
        if (conv_end) begin
          osr_cnt_q <= '0;
          acc_q <= '0;
        end else begin
          osr_cnt_q <= osr_cnt_q + 1'b1;
          acc_q <= acc_q + CW'(bit_val_q);
        end
      end else begin
        osr_cnt_q <= '0;
        acc_q <= '0;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Four-entry decimator pipeline, one generate per entry.
  logic [CW-1:0] conv_val;
  assign conv_val = acc_q + CW'(bit_val_q);
  for (genvar i = 0; i < SDAS_PIPE_DEPTH; i++) begin : g_pipe
    always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
        pipe_q[i] <= '0;
      end else if (clk_en_in && conv_end) begin
        if (i == 0) begin
          pipe_q[i] <= conv_val;
        end else begin
          pipe_q[i] <= pipe_q[i-1];
        end
      end
    end
  end
  // Result is the sum of the new conversion and the three before it.
  assign pipe_sum = SW'(conv_val) + SW'(pipe_q[0]) + SW'(pipe_q[1])
    + SW'(pipe_q[2]);
  // Fill level; a mux change or a restart empties it again.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      fill_q <= 3'h0;
    end else if (clk_en_in) begin
      if (mux_pulse || state_q == SDAS_ST_STANDBY ||
          state_q == SDAS_ST_WAIT) begin
        fill_q <= 3'h0;
      end else if (conv_end && fill_q < 3'(SDAS_PIPE_DEPTH)) begin
        fill_q <= fill_q + 3'h1;
      end
    end
  end
  // Valid from the fourth conversion on since the pipeline was emptied.
  assign result_ready = conv_end && !mux_pulse &&
    (fill_q >= 3'(SDAS_PRIME_CONV));
  //////////////////////////////////////////////////////////////////////
  // Sequencer. WAIT holds single mode until the result is taken, and
  // holds restart modes while the pipeline is cleared.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= SDAS_ST_STANDBY;
    end else if (clk_en_in) begin
      case (state_q)
        SDAS_ST_STANDBY: begin
          if (start_ev) begin
            state_q <= SDAS_ST_PRIME;
          end
        end
        SDAS_ST_PRIME: begin
          if (stop_in) begin
            state_q <= SDAS_ST_STANDBY;
          end else if (result_ready) begin
            if (cfg_in.mode == SDAS_MODE_SINGLE) begin
              state_q <= SDAS_ST_WAIT;
            end else if (restart_each) begin
              state_q <= SDAS_ST_WAIT;
            end else begin
              state_q <= SDAS_ST_RUN;
            end
          end
        end
        SDAS_ST_RUN: begin
          // Continuous and long turbo keep the pipeline primed.
          if (stop_in) begin
            state_q <= SDAS_ST_STANDBY;
          end
        end
        SDAS_ST_WAIT: begin
          if (cfg_in.mode == SDAS_MODE_SINGLE) begin
            if (result_read_in) begin
              state_q <= SDAS_ST_STANDBY;
            end
          end else if (stop_in) begin
            state_q <= SDAS_ST_STANDBY;
          end else begin
            state_q <= SDAS_ST_PRIME;
          end
        end
        default: begin
          state_q <= SDAS_ST_STANDBY;
        end
      endcase
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Result, status and done. A new result wins over a same-cycle read
  // so no completion is ever lost.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      result_out <= '0;
      status_out <= SDAS_DONE_RST;
      done_out <= SDAS_DONE_RST;
    end else if (clk_en_in) begin
      if (result_ready && state_q != SDAS_ST_STANDBY) begin
        result_out <= RES_W'(pipe_sum);
        status_out <= 1'b1;
        done_out <= 1'b1;
      end else if (result_read_in) begin
        status_out <= 1'b0;
        done_out <= 1'b0;
      end
    end
  end
  // Busy shows a conversion in progress.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      busy_out <= 1'b0;
    end else if (clk_en_in) begin
      busy_out <= (state_q == SDAS_ST_PRIME) || (state_q == SDAS_ST_RUN);
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Checks.
  // Converting cycles since the pipeline was last emptied. This is kept
  // apart from the fill count, so that the priming check does not lean
  // on the very logic that it guards.
  logic [15:0] since_empty_q;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      since_empty_q <= 16'h0000;
    end else if (clk_en_in) begin
      if (mux_pulse || state_q == SDAS_ST_STANDBY ||
          state_q == SDAS_ST_WAIT) begin
        since_empty_q <= 16'h0000;
      end else if (since_empty_q != 16'hffff) begin
        since_empty_q <= since_empty_q + 16'h0001;
      end
    end
  end
  sequence s_complete;
    clk_en_in && result_ready && state_q != SDAS_ST_STANDBY;
  endsequence
  AST_DONE_ON_END: assert property (@(posedge clk_in)
    disable iff (!resetn_in) s_complete |=> done_out && status_out)
    else $error("done not raised after conversion end");
  AST_READ_CLEARS: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    clk_en_in && result_read_in && !result_ready |=> !done_out)
    else $error("read did not clear done");
  AST_DONE_HOLDS: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    done_out && !result_read_in |=> done_out)
    else $error("done dropped without a read");
  AST_PRIME_FOUR: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    clk_en_in && result_ready |->
    since_empty_q >= 16'(SDAS_PRIME_CONV * OSR))
    else $error("result before pipeline primed");
  AST_MUX_INVALID: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    clk_en_in && mux_pulse |=> fill_q == 3'h0)
    else $error("mux change did not invalidate pipeline");
  AST_STANDBY_IDLE: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    state_q == SDAS_ST_STANDBY && clk_en_in && !start_ev
    |=> state_q == SDAS_ST_STANDBY)
    else $error("left standby without a start");
  AST_START: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    state_q == SDAS_ST_STANDBY && clk_en_in && start_ev
    |=> state_q == SDAS_ST_PRIME ##1 busy_out)
    else $error("start not taken");
  AST_MULTI_AUTO: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    state_q == SDAS_ST_WAIT && clk_en_in && !stop_in &&
    cfg_in.mode != SDAS_MODE_SINGLE |=> state_q == SDAS_ST_PRIME)
    else $error("multi sample did not restart");
  AST_SINGLE_BACK: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    state_q == SDAS_ST_WAIT && clk_en_in && result_read_in &&
    cfg_in.mode == SDAS_MODE_SINGLE |=> state_q == SDAS_ST_STANDBY)
    else $error("single mode did not return to standby");
  // A completion while priming, with no stop pending, picks the next step.
  sequence s_prime_result;
    clk_en_in && state_q == SDAS_ST_PRIME && result_ready && !stop_in;
  endsequence
  AST_SINGLE_WAIT: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    s_prime_result ##0 (cfg_in.mode == SDAS_MODE_SINGLE)
    |=> state_q == SDAS_ST_WAIT && done_out)
    else $error("single result did not wait for a read");
  AST_REPRIME: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    s_prime_result ##0 (restart_each)
    |=> state_q == SDAS_ST_WAIT)
    else $error("restart mode kept the pipeline primed");
  AST_LONG_RUN: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    s_prime_result ##0 (cfg_in.mode == SDAS_MODE_CONT || turbo_long)
    |=> state_q == SDAS_ST_RUN)
    else $error("primed run did not keep converting");
  AST_RUN_HOLDS: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    clk_en_in && state_q == SDAS_ST_RUN && !stop_in
    |=> state_q == SDAS_ST_RUN)
    else $error("continuous run stopped without a stop");
  // A low clock enable must hold the sequencer, the done flag and the result.
  AST_FREEZE: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    !clk_en_in |=> $stable(state_q) && $stable(done_out) &&
    $stable(result_out))
    else $error("state moved while the clock enable was low");
endmodule : sdas_sequencer
`default_nettype wire

// [verification/sdas_reader_model.sv]
// Reader model: a DMA or CPU that takes a result once done is raised.
// Assumes the sequencer's clock and its active-low async reset.
`timescale 1ns/1ps
`default_nettype none
module sdas_reader_model (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic enable_in,
  input wire logic [3:0] delay_in,
  input wire logic done_in,
  output logic read_out
);
  logic [3:0] wait_q; // Cycles that done has stood unread.
  logic read_q; // One-cycle read pulse.
  //////////////////////////////////////////////////////////////////////
  // Done serves as the request; the read follows delay_in + 1 cycles after done rises,
  // so a slow reader is modelled too.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wait_q <= 4'h0;
      read_q <= 1'b0;
    end else if (!enable_in || !done_in || read_q) begin
      wait_q <= 4'h0;
      read_q <= 1'b0;
    end else if (wait_q == delay_in) begin
      read_q <= 1'b1;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
  assign read_out = read_q;
endmodule : sdas_reader_model
`default_nettype wire

// [verification/tb_sigma_delta_adc_sequencer.sv]
// Self-checking bench for the conversion sequencer.
// Assumes a reader model answers done; OSR is shortened to 4.
`timescale 1ns/1ps
`default_nettype none
module tb_sigma_delta_adc_sequencer;
  import sdas_pkg::*;
  localparam int OSR_SIM = 4;
  typedef struct packed {
    sdas_mode_e mode;
    logic [4:0] res;
    logic mod;
    logic [19:0] exp;
  } sdas_row_s;
  localparam sdas_row_s ROWS [8] = '{
    '{SDAS_MODE_SINGLE, 5'h10, 1'b0, 20'h0_0000},
    '{SDAS_MODE_SINGLE, 5'h10, 1'b1, 20'h0_0010},
    '{SDAS_MODE_MULTI, 5'h0c, 1'b1, 20'h0_0010},
    '{SDAS_MODE_MULTI, 5'h14, 1'b0, 20'h0_0000},
    '{SDAS_MODE_CONT, 5'h10, 1'b1, 20'h0_0010},
    '{SDAS_MODE_CONT, 5'h08, 1'b0, 20'h0_0000},
    '{SDAS_MODE_TURBO, 5'h10, 1'b1, 20'h0_0010},
    '{SDAS_MODE_TURBO, 5'h14, 1'b1, 20'h0_0010}};
  logic clk_in, resetn_in, start_bit_in, start_strobe_in, stop_in;
  logic mod_bit_in, mux_change_in, result_read_in, rd_en, clk_en;
  logic done_out, status_out, busy_out;
  logic [3:0] rd_delay;
  logic [19:0] result_out;
  sdas_cfg_s cfg_in;
  int fail_count, n_tests, lat;
  sdas_sequencer #(.OSR(OSR_SIM), .RES_W(20)) i_sdas_sequencer (
    .clk_in(clk_in), .resetn_in(resetn_in), .clk_en_in(clk_en),
    .cfg_in(cfg_in), .start_bit_in(start_bit_in),
    .start_strobe_in(start_strobe_in), .stop_in(stop_in),
    .mod_bit_in(mod_bit_in), .mux_change_in(mux_change_in),
    .result_read_in(result_read_in), .result_out(result_out),
    .done_out(done_out), .status_out(status_out), .busy_out(busy_out));
  sdas_reader_model i_sdas_reader_model (.clk_in(clk_in),
    .resetn_in(resetn_in), .enable_in(rd_en), .delay_in(rd_delay),
    .done_in(done_out), .read_out(result_read_in));
  //////////////////////////////////////////////////////////////////////
  // The 5 ns clock.
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  // Counts every compare and reports a difference at once.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict();
    $display("compares %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict
  // Steps past an edge so that its updates have landed.
  task automatic tick();
    @(posedge clk_in);
    #1;
  endtask : tick
  // Bounded wait: 0 done high, 1 idle and clear, 2 a read pulse.
  task automatic wait_for(input int sel, output int n);
    logic hit;
    n = 0;
    hit = 1'b0;
    while (!hit) begin
      tick();
      n++;
      case (sel)
        0: hit = (done_out === 1'b1);
        1: hit = (busy_out === 1'b0 && done_out === 1'b0);
        default: hit = (result_read_in === 1'b1);
      endcase
      if (n > 400) begin
        check(32'h0, 32'h1);
        print_verdict();
      end
    end
  endtask : wait_for
  // A one-cycle software start pulse.
  task automatic start_conv();
    @(posedge clk_in) start_bit_in <= 1'b1;
    @(posedge clk_in) start_bit_in <= 1'b0;
    #1;
  endtask : start_conv
  // Sets mode and bit level, lets the modulator settle, then starts.
  task automatic setup(input sdas_row_s r);
    @(posedge clk_in) cfg_in <= '{r.mode, r.res};
    mod_bit_in <= r.mod;
    repeat (6) @(posedge clk_in);
    start_conv();
  endtask : setup
  // Ends a free-running mode and waits for standby.
  task automatic finish_run();
    @(posedge clk_in) stop_in <= 1'b1;
    @(posedge clk_in) stop_in <= 1'b0;
    wait_for(1, lat);
  endtask : finish_run
  //////////////////////////////////////////////////////////////////////
  initial begin
    {resetn_in, start_bit_in, start_strobe_in, stop_in} = 4'h0;
    {mod_bit_in, mux_change_in} = 2'h0;
    cfg_in = '{SDAS_MODE_SINGLE, 5'h10};
    rd_en = 1'b1;
    clk_en = 1'b1;
    rd_delay = 4'h2;
    fail_count = 0;
    n_tests = 0;
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    tick();
    check({done_out, status_out, busy_out}, 32'h0);
    // Table rows cover every mode; all but turbo at both bit levels, turbo with ones only.
    foreach (ROWS[i]) begin
      setup(ROWS[i]);
      wait_for(0, lat);
      check(result_out, ROWS[i].exp);
      check(status_out, 1'b1);
      wait_for(2, lat);
      tick();
      if (ROWS[i].mode == SDAS_MODE_SINGLE) begin
        check({done_out, status_out}, 32'h0);
      end
      finish_run();
    end
    // Unread result stands; single mode then returns to standby.
    rd_en = 1'b0;
    setup(ROWS[1]);
    wait_for(0, lat);
    repeat (20) tick();
    check({done_out, busy_out}, 32'h2);
    rd_en = 1'b1;
    wait_for(2, lat);
    tick();
    check(done_out, 1'b0);
    repeat (3) tick();
    check(busy_out, 1'b0);
    // Start from the external strobe, held past its filter.
    @(posedge clk_in) start_strobe_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    start_strobe_in <= 1'b0;
    wait_for(0, lat);
    check(result_out, 20'h0_0010);
    wait_for(1, lat);
    // An input change mid-run delays the result by a full refill; it is
    // only ever made in single mode, never while running continuously.
    start_conv();
    repeat (5) @(posedge clk_in);
    mux_change_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    mux_change_in <= 1'b0;
    wait_for(0, lat);
    check(lat + 8 >= 6 + 4 * OSR_SIM, 1'b1);
    wait_for(1, lat);
    // A low clock enable holds a run, which then resumes where it stood.
    setup(ROWS[1]);
    @(posedge clk_in) clk_en <= 1'b0;
    repeat (40) tick();
    check({done_out, busy_out}, 32'h1);
    @(posedge clk_in) clk_en <= 1'b1;
    wait_for(0, lat);
    check(result_out, 20'h0_0010);
    wait_for(1, lat);
    // Gap between results: re-primed runs against the long turbo run.
    rd_delay = 4'h0;
    for (int k = 0; k < 3; k++) begin
      setup('{k == 0 ? SDAS_MODE_MULTI : SDAS_MODE_TURBO,
        k == 2 ? 5'h11 : 5'h10, 1'b1, 20'h0_0010});
      wait_for(0, lat);
      wait_for(2, lat);
      tick();
      wait_for(0, lat);
      if (k == 2) check(lat <= OSR_SIM, 1'b1);
      else check(lat >= 3 * OSR_SIM, 1'b1);
      finish_run();
    end
    // Reset in mid-run returns everything to standby.
    start_conv();
    repeat (5) @(posedge clk_in);
    resetn_in <= 1'b0;
    tick();
    check({done_out, status_out, busy_out}, 32'h0);
    // After a second release nothing is left converting.
    @(posedge clk_in) resetn_in <= 1'b1;
    repeat (2) tick();
    check({done_out, status_out, busy_out}, 32'h0);
    print_verdict();
  end
endmodule : tb_sigma_delta_adc_sequencer
`default_nettype wire
